// file: include/rre_pkg.sv
package rre_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int         DATA_W    = 8;
  localparam int         FLAG_W    = 4;
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [7:0] INTERRUPT_CONTROL_REG_RST  = 8'h00;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GIE_BIT = 0;
  localparam int FLAG_C  = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_Z  = 2;
  localparam int FLAG_OV = 3;

  // ----------------------------------------------------------------
  // Operation codes and timing
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_RETURN                        = 3'h0;
  localparam logic [2:0] OP_RETURN_WITH_LITERAL           = 3'h1;
  localparam logic [2:0] OP_RETURN_FROM_IRQ               = 3'h2;
  localparam logic [2:0] OP_ROTATE_LEFT                   = 3'h3;
  localparam logic [2:0] OP_ROTATE_LEFT_TO_ACC            = 3'h4;
  localparam logic [2:0] OP_ROTATE_LEFT_THRU_CARRY        = 3'h5;
  localparam logic [2:0] OP_ROTATE_LEFT_THRU_CARRY_TO_ACC = 3'h6;
  localparam logic [2:0] OP_ROTATE_RIGHT                  = 3'h7;
  localparam int         RETURN_CYCLES                    = 2;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RRE_IDLE     = 2'b01,
    RRE_RET_WAIT = 2'b10
  } rre_state_t;

  typedef struct packed {
    rre_state_t  state;
    logic        ready;
    logic [7:0]  acc;
    logic [3:0]  flags;
    logic [7:0]  intCtrl;
    logic        memWrite;
    logic [7:0]  memWdata;
    logic        stackPop;
    logic        done;
    logic [2:0]  pendOp;
    logic [7:0]  pendLit;
  } rre_regs_t;

endpackage

// file: verilog/rre_rotator.sv
`timescale 1ns/100ps
`default_nettype none
module rre_rotator #(
  parameter int DATA_W = 8
) (
  // Operand
  input  wire logic [DATA_W-1:0] dataIn,
  input  wire logic              carryIn,
  // Mode
  input  wire logic              left,
  input  wire logic              thruCarry,
  // Result
  output logic      [DATA_W-1:0] result,
  output logic                   carryOut
);

  if (DATA_W < 2) begin : gWidthCheck
    $error("rre_rotator needs DATA_W of at least 2");
  end

  // ----------------------------------------------------------------
  // Rotation
  // ----------------------------------------------------------------
  // Through-carry mode makes the carry the extra ninth bit of the ring
  always_comb begin
    if (left) begin
      result   = {dataIn[DATA_W-2:0], thruCarry ? carryIn : dataIn[DATA_W-1]};
      carryOut = thruCarry ? dataIn[DATA_W-1] : carryIn;
    end else begin
      result   = {thruCarry ? carryIn : dataIn[0], dataIn[DATA_W-1:1]};
      carryOut = thruCarry ? dataIn[0] : carryIn;
    end
  end

endmodule
`default_nettype wire

// file: verilog/rre_exec.sv
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Return-with-literal pops the return address and loads the 8-bit literal into acc.
// - Return-from-irq pops the return address and sets the global interrupt enable.
// - Global interrupt enable sits at bit 0 of the interrupt control register.
// - Rotate left: bit 7 wraps into bit 0, result written back to memory.
// - Rotate left to acc: same rotation, result to acc, memory untouched.
// - Rotate left through carry: nine-bit ring, old bit 7 to carry, back to memory.
// - Same nine-bit rotation with carry update, result to acc, memory untouched.
// - Rotate right: bit 0 wraps into bit 7, result written back to memory.
// - Plain return takes two machine cycles to restore the program counter.
module rre_exec (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  input  wire logic                        clkEn,
  // Command
  input  wire logic                        cmdValid,
  input  wire logic [2:0]                  cmdOp,
  input  wire logic [rre_pkg::DATA_W-1:0]  memData,
  input  wire logic [rre_pkg::DATA_W-1:0]  literal,
  output logic                             cmdReady,
  output logic                             done,
  // Side loads from the rest of the core
  input  wire logic                        intCtrlWrite,
  input  wire logic [rre_pkg::DATA_W-1:0]  intCtrlWdata,
  input  wire logic                        flagsWrite,
  input  wire logic [rre_pkg::FLAG_W-1:0]  flagsWdata,
  // Architectural state
  output logic      [rre_pkg::DATA_W-1:0]  accOut,
  output logic      [rre_pkg::FLAG_W-1:0]  flagsOut,
  output logic      [rre_pkg::DATA_W-1:0]  intCtrlOut,
  // Data memory and return stack
  output logic                             memWrite,
  output logic      [rre_pkg::DATA_W-1:0]  memWdata,
  output logic                             stackPop
);
  import rre_pkg::*;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic isReturn(input logic [2:0] op);
    isReturn = (op == OP_RETURN) || (op == OP_RETURN_WITH_LITERAL) ||
               (op == OP_RETURN_FROM_IRQ);
  endfunction

  function automatic logic isThru(input logic [2:0] op);
    isThru = (op == OP_ROTATE_LEFT_THRU_CARRY) || (op == OP_ROTATE_LEFT_THRU_CARRY_TO_ACC);
  endfunction

  function automatic logic isToAcc(input logic [2:0] op);
    isToAcc = (op == OP_ROTATE_LEFT_TO_ACC) || (op == OP_ROTATE_LEFT_THRU_CARRY_TO_ACC);
  endfunction

  rre_regs_t          r_reg;
  rre_regs_t          r_next;
  logic      [7:0]    rotResult;
  logic               rotCarry;
  logic               take;

  assign take = cmdValid && r_reg.ready && (r_reg.state == RRE_IDLE);

  // ----------------------------------------------------------------
  // Rotation unit
  // ----------------------------------------------------------------
  rre_rotator #(
    .DATA_W    (DATA_W)
  ) uRot (
    .dataIn    (memData),
    .carryIn   (r_reg.flags[FLAG_C]),
    .left      (cmdOp != OP_ROTATE_RIGHT),
    .thruCarry (isThru(cmdOp)),
    .result    (rotResult),
    .carryOut  (rotCarry)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next          = r_reg;
    r_next.memWrite = 1'b0;
    r_next.stackPop = 1'b0;
    r_next.done     = 1'b0;
    // Core-side loads first so that this block's own updates win
    if (intCtrlWrite) begin
      r_next.intCtrl = intCtrlWdata;
    end
    if (flagsWrite) begin
      r_next.flags = flagsWdata;
    end
    case (r_reg.state)
      RRE_IDLE: begin
        if (take) begin
          if (isReturn(cmdOp)) begin
            // Pop now, finish one cycle later while fetch refills
            r_next.state    = RRE_RET_WAIT;
            r_next.ready    = 1'b0;
            r_next.stackPop = 1'b1;
            r_next.pendOp   = cmdOp;
            r_next.pendLit  = literal;
          end else begin
            r_next.done = 1'b1;
            if (isToAcc(cmdOp)) begin
              r_next.acc = rotResult;
            end else begin
              r_next.memWrite = 1'b1;
              r_next.memWdata = rotResult;
            end
            if (isThru(cmdOp)) begin
              r_next.flags[FLAG_C] = rotCarry;
            end
          end
        end
      end
      RRE_RET_WAIT: begin
        r_next.state = RRE_IDLE;
        r_next.ready = 1'b1;
        r_next.done  = 1'b1;
        if (r_reg.pendOp == OP_RETURN_WITH_LITERAL) begin
          r_next.acc = r_reg.pendLit;
        end
        // Set beats a same-cycle software clear of the enable
        if (r_reg.pendOp == OP_RETURN_FROM_IRQ) begin
          r_next.intCtrl[GIE_BIT] = 1'b1;
        end
      end
      default: begin
        r_next.state = RRE_IDLE;
        r_next.ready = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg.state    <= RRE_IDLE;
      r_reg.ready    <= 1'b1;
      r_reg.acc      <= ACC_RST;
      r_reg.flags    <= FLAGS_RST;
      r_reg.intCtrl  <= INTERRUPT_CONTROL_REG_RST;
      r_reg.memWrite <= 1'b0;
      r_reg.memWdata <= 8'h00;
      r_reg.stackPop <= 1'b0;
      r_reg.done     <= 1'b0;
      r_reg.pendOp   <= OP_RETURN;
      r_reg.pendLit  <= 8'h00;
    end else if (clkEn) begin
      r_reg <= r_next;
    end
  end

  assign cmdReady   = r_reg.ready;
  assign done       = r_reg.done;
  assign accOut     = r_reg.acc;
  assign flagsOut   = r_reg.flags;
  assign intCtrlOut = r_reg.intCtrl;
  assign memWrite   = r_reg.memWrite;
  assign memWdata   = r_reg.memWdata;
  assign stackPop   = r_reg.stackPop;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [7:0] expRol;
  logic [7:0] expRolc;
  logic [7:0] expRor;
  logic       carryNow;
  assign expRol   = {memData[6:0], memData[7]};
  assign expRolc  = {memData[6:0], r_reg.flags[FLAG_C]};
  assign expRor   = {memData[0], memData[7:1]};
  assign carryNow = r_reg.flags[FLAG_C];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  ret_pop_a: assert property (
    take && isReturn(cmdOp) && clkEn |=> stackPop && !done && !cmdReady)
    else $error("return did not pop in its first cycle");
  ret_two_cycle_a: assert property (
    take && isReturn(cmdOp) && clkEn ##1 clkEn |=> done && !stackPop && cmdReady)
    else $error("return did not finish in its second cycle");
  lit_acc_a: assert property (
    take && cmdOp == OP_RETURN_WITH_LITERAL && clkEn ##1 clkEn |=> accOut == $past(literal, 2))
    else $error("literal not loaded into accumulator");
  irq_enable_a: assert property (
    take && cmdOp == OP_RETURN_FROM_IRQ && clkEn ##1 clkEn |=> intCtrlOut[GIE_BIT])
    else $error("global interrupt enable not set");
  rol_mem_a: assert property (
    take && cmdOp == OP_ROTATE_LEFT && clkEn |=> memWrite && memWdata == $past(expRol))
    else $error("rotate left result wrong");
  rol_acc_a: assert property (
    take && cmdOp == OP_ROTATE_LEFT_TO_ACC && clkEn |=> !memWrite && accOut == $past(expRol))
    else $error("rotate left to acc result wrong");
  rolc_mem_a: assert property (
    take && cmdOp == OP_ROTATE_LEFT_THRU_CARRY && clkEn |=>
      memWrite && memWdata == $past(expRolc) && carryNow == $past(memData[7]))
    else $error("rotate left through carry wrong");
  rolc_acc_a: assert property (
    take && cmdOp == OP_ROTATE_LEFT_THRU_CARRY_TO_ACC && clkEn |=>
      !memWrite && accOut == $past(expRolc) && carryNow == $past(memData[7]))
    else $error("rotate left through carry to acc wrong");
  ror_mem_a: assert property (
    take && cmdOp == OP_ROTATE_RIGHT && clkEn |=> memWrite && memWdata == $past(expRor))
    else $error("rotate right result wrong");
  flags_keep_a: assert property (
    take && !isThru(cmdOp) && !flagsWrite && clkEn |=> $stable(flagsOut))
    else $error("flags changed by a flag-neutral operation");

  ret_irq_c: cover property (take && cmdOp == OP_RETURN_FROM_IRQ ##2 done);
  rolc_c: cover property (take && cmdOp == OP_ROTATE_LEFT_THRU_CARRY && memData[7]);
  back_to_back_c: cover property (take && !isReturn(cmdOp) ##1 take);

endmodule
`default_nettype wire

// file: tb/rre_exec_bench.sv
`timescale 1ns/100ps
`default_nettype none
module rre_exec_bench;
  import rre_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic       clk          = 1'b0;
  logic       arst_n       = 1'b0;
  logic       clkEn        = 1'b1;
  logic       cmdValid     = 1'b0;
  logic [2:0] cmdOp        = 3'h0;
  logic [7:0] memData      = 8'h00;
  logic [7:0] literal      = 8'h00;
  logic       intCtrlWrite = 1'b0;
  logic [7:0] intCtrlWdata = 8'h00;
  logic       flagsWrite   = 1'b0;
  logic [3:0] flagsWdata   = 4'h0;
  wire logic       cmdReady, done, memWrite, stackPop;
  wire logic [7:0] accOut, intCtrlOut, memWdata;
  wire logic [3:0] flagsOut;
  int         fails        = 0;
  int         num_checks   = 0;
  logic [7:0] accExp       = 8'h00;
  logic [7:0] wdExp        = 8'h00;

  always #25 clk = ~clk;

  rre_exec dut (.clk(clk), .arst_n(arst_n), .clkEn(clkEn), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .memData(memData), .literal(literal), .cmdReady(cmdReady),
    .done(done), .intCtrlWrite(intCtrlWrite), .intCtrlWdata(intCtrlWdata),
    .flagsWrite(flagsWrite), .flagsWdata(flagsWdata), .accOut(accOut),
    .flagsOut(flagsOut), .intCtrlOut(intCtrlOut), .memWrite(memWrite),
    .memWdata(memWdata), .stackPop(stackPop));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic step();
    @(posedge clk);
    @(negedge clk);
  endtask

  // Bounded wait so a stuck ready cannot hang the run
  task automatic wait_ready();
    int n;
    n = 0;
    while (cmdReady !== 1'b1 && n < 4) begin
      step();
      n++;
    end
    if (cmdReady !== 1'b1) begin
      fails++;
      $display("ERROR cmdReady expected 1 seen %b", cmdReady);
      finish_test();
    end
  endtask

  // Own model of the rotations: {carry, byte}
  function automatic logic [8:0] rot(input logic [2:0] op, input logic [7:0] m,
                                     input logic c);
    case (op)
      OP_ROTATE_LEFT, OP_ROTATE_LEFT_TO_ACC: rot = {c, m[6:0], m[7]};
      OP_ROTATE_RIGHT:                       rot = {c, m[0], m[7:1]};
      default:                               rot = {m[7], m[6:0], c};
    endcase
  endfunction

  task automatic load_side(input logic [7:0] ic, input logic [3:0] fl);
    intCtrlWrite = 1'b1;
    intCtrlWdata = ic;
    flagsWrite   = 1'b1;
    flagsWdata   = fl;
    step();
    intCtrlWrite = 1'b0;
    flagsWrite   = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    arst_n = 1'b0;
    repeat (5) step();
    chk("ready in reset", 8'h01, {7'h0, cmdReady});
    arst_n = 1'b1;
    step();
    chk("acc after reset", ACC_RST, accOut);
    chk("interrupt_control_reg after reset", INTERRUPT_CONTROL_REG_RST, intCtrlOut);
    chk("flags after reset", {4'h0, FLAGS_RST}, {4'h0, flagsOut});
    chk("pulses after reset", 8'h00, {5'h0, done, memWrite, stackPop});
    accExp = ACC_RST;
    wdExp  = 8'h00;
    $display("test_reset finished");
  endtask

  // Back-to-back rotates, every code, with cmdValid held high throughout
  task automatic test_rotates();
    logic [2:0] ops [7];
    logic [7:0] dat [7];
    logic [3:0] fl;
    logic [8:0] r;
    ops = '{3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h5, 3'h6};
    dat = '{8'h81, 8'h81, 8'h81, 8'h40, 8'h01, 8'h80, 8'h7f};
    fl = 4'he;
    load_side(8'h00, fl);
    wait_ready();
    for (int i = 0; i < 7; i++) begin
      cmdValid = 1'b1;
      cmdOp    = ops[i];
      memData  = dat[i];
      r = rot(ops[i], dat[i], fl[FLAG_C]);
      step();
      if (ops[i] == OP_ROTATE_LEFT_TO_ACC || ops[i] == OP_ROTATE_LEFT_THRU_CARRY_TO_ACC) begin
        accExp = r[7:0];
        chk("mem write on acc form", 8'h00, {7'h0, memWrite});
      end else begin
        wdExp = r[7:0];
        chk("mem write", 8'h01, {7'h0, memWrite});
      end
      fl[FLAG_C] = r[8];
      chk("write data", wdExp, memWdata);
      chk("acc", accExp, accOut);
      chk("flags", {4'h0, fl}, {4'h0, flagsOut});
      chk("done", 8'h01, {7'h0, done});
    end
    cmdValid = 1'b0;
    step();
    chk("pulses idle", 8'h00, {6'h0, done, memWrite});
    $display("test_rotates finished");
  endtask

  // Each return: pop, then done one cycle after the pop, with a refused request between
  task automatic test_returns();
    for (int k = 0; k < 3; k++) begin
      load_side(8'h5a, 4'h9);
      wait_ready();
      cmdValid = 1'b1;
      cmdOp    = 3'(k);
      literal  = 8'hc3 + 8'(k);
      step();
      literal = 8'h00;
      cmdOp   = OP_ROTATE_LEFT;
      memData = 8'hff;
      chk("pop and ready", 8'h02, {6'h0, stackPop, cmdReady});
      chk("early done", 8'h00, {7'h0, done});
      step();
      cmdValid = 1'b0;
      if (3'(k) == OP_RETURN_WITH_LITERAL) accExp = 8'hc3 + 8'(k);
      chk("done and ready", 8'h03, {6'h0, done, cmdReady});
      chk("pop and write", 8'h00, {6'h0, stackPop, memWrite});
      chk("acc", accExp, accOut);
      chk("interrupt_control_reg", (k == 2) ? 8'h5b : 8'h5a, intCtrlOut);
      chk("flags", 8'h09, {4'h0, flagsOut});
    end
    $display("test_returns finished");
  endtask

  // Block's own carry and enable updates must beat same-cycle side loads
  task automatic test_conflicts();
    load_side(8'h00, 4'h0);
    wait_ready();
    cmdValid   = 1'b1;
    cmdOp      = OP_ROTATE_LEFT_THRU_CARRY;
    memData    = 8'h80;
    flagsWrite = 1'b1;
    flagsWdata = 4'h6;
    step();
    flagsWrite = 1'b0;
    wdExp      = 8'h00;
    chk("carry over load", 8'h07, {4'h0, flagsOut});
    chk("write data", wdExp, memWdata);
    cmdOp = OP_RETURN_FROM_IRQ;
    step();
    cmdValid     = 1'b0;
    intCtrlWrite = 1'b1;
    intCtrlWdata = 8'ha4;
    step();
    intCtrlWrite = 1'b0;
    chk("enable over load", 8'ha5, intCtrlOut);
    chk("done", 8'h01, {7'h0, done});
    $display("test_conflicts finished");
  endtask

  // Low clock enable must freeze takes, results and pulses
  task automatic test_clk_enable();
    step();
    wait_ready();
    clkEn    = 1'b0;
    cmdValid = 1'b1;
    cmdOp    = OP_ROTATE_LEFT_TO_ACC;
    memData  = 8'h12;
    step();
    chk("acc frozen", accExp, accOut);
    chk("done frozen", 8'h00, {7'h0, done});
    clkEn = 1'b1;
    step();
    accExp = 8'h24;
    chk("acc", accExp, accOut);
    chk("done", 8'h01, {7'h0, done});
    clkEn    = 1'b0;
    cmdValid = 1'b0;
    step();
    chk("done stretched", 8'h01, {7'h0, done});
    chk("acc held", accExp, accOut);
    clkEn = 1'b1;
    step();
    chk("done cleared", 8'h00, {7'h0, done});
    $display("test_clk_enable finished");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    test_reset();
    test_rotates();
    test_returns();
    test_conflicts();
    test_clk_enable();
    test_reset();
    finish_test();
  end
endmodule
`default_nettype wire
